/* hdl/xfls_pkg.sv */
/*
  shared constants and carrier types for the crystal configuration and
  loop lock status block.
  assumes a 32-bit apb slave port and a single 200 MHz clock.
*/
package xfls_pkg;

  localparam int AW = 12;
  localparam int DW = 32;

  // register byte addresses
  localparam logic [AW-1:0] CFG_OFS = 12'h000;
  localparam logic [AW-1:0] STS_OFS = 12'h004;

  // crystal_osc_config field positions
  localparam int CFG_BYPASS_BIT = 4;
  localparam int CFG_RANGE_LSB  = 2;
  localparam int CFG_AGC_BIT    = 1;
  localparam int CFG_AUTO_BIT   = 0;

  // loop_lock_status field positions
  localparam int STS_WARN_BIT   = 13;
  localparam int STS_ULPUC_BIT  = 12;
  localparam int STS_HIST_LSB   = 10;
  localparam int STS_UNLOCK_LSB = 8;
  localparam int STS_CNTEN_BIT  = 6;
  localparam int STS_ULIFG_BIT  = 4;
  localparam int STS_REFRDY_BIT = 2;
  localparam int STS_XTFLT_BIT  = 1;
  localparam int STS_LPFLT_BIT  = 0;

  // reset values
  localparam logic       AUTO_OFF_RST = 1'h1;
  localparam logic [1:0] RANGE_RST    = 2'h0;
  localparam logic [1:0] HIST_RST     = 2'h1;
  localparam logic [1:0] UNLOCK_RST   = 2'h3;
  localparam logic       CNT_EN_RST   = 1'h1;

  // unlock codes
  localparam logic [1:0] UNLOCK_LOCKED = 2'h0;
  localparam logic [1:0] UNLOCK_SLOW   = 2'h1;
  localparam logic [1:0] UNLOCK_FAST   = 2'h2;
  localparam logic [1:0] UNLOCK_ERROR  = 2'h3;

  // loop oscillator tap limits
  localparam logic [8:0] TAP_MIN = 9'h000;
  localparam logic [8:0] TAP_MAX = 9'h1ff;

  // start fault counter
  localparam int         START_CW    = 8;
  localparam logic [7:0] START_LIMIT = 8'hc8;

  typedef struct packed {
    logic          psel;
    logic          penable;
    logic          pwrite;
    logic [AW-1:0] paddr;
    logic [DW-1:0] pwdata;
  } xfls_apb_req_t;

  typedef struct packed {
    logic       too_slow;
    logic       too_fast;
    logic       out_of_range;
    logic [8:0] tap;
  } xfls_loop_sts_t;

  typedef struct packed {
    logic q;
  } xfls_flag_t;

  typedef struct packed {
    logic [START_CW-1:0] cnt;
    logic                fault;
  } xfls_cnt_t;

  typedef struct packed {
    logic          bypass;
    logic [1:0]    range;
    logic          agc_off;
    logic          auto_off;
    logic          warn_en;
    logic          ulpuc_en;
    logic          cnt_en;
    logic [1:0]    unlock_now;
    logic          ulifg;
    logic          ref_ready;
    logic          xtal_en;
    logic          from_pin;
    logic [1:0]    hf_range;
    logic          agc_out;
    logic          irq;
    logic          puc_req;
    logic          pready;
    logic          pslverr;
    logic [DW-1:0] prdata;
  } xfls_state_t;

endpackage

/* hdl/xfls_sticky.sv */
/*
  one sticky status bit: hardware sets, software clears.
  assumes set and clr are synchronous single-cycle or level terms.
*/
`timescale 1ns/100ps
module xfls_sticky #(
  parameter logic RST_VAL = 1'h0
) (
  input  wire logic pclk,    // system clock
  input  wire logic presetn, // async reset, low
  input  wire logic set,     // hardware set
  input  wire logic clr,     // software clear
  output logic      q        // flag
);
  import xfls_pkg::*;

  xfls_flag_t st;
  xfls_flag_t next_st;

  always_comb begin
    next_st = st;
    if (set) begin
      next_st.q = 1'b1;
    end else if (clr) begin
      next_st.q = 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st.q <= RST_VAL;
    end else begin
      st <= next_st;
    end
  end

  assign q = st.q;

  property p_set_wins;
    @(posedge pclk) disable iff (!presetn) set |=> q;
  endproperty
  a_set_wins: assert property (p_set_wins) else $error("flag lost its set");

endmodule // xfls_sticky

/* hdl/xfls_start_cnt.sv */
/*
  crystal start fault counter: counts faulty start cycles while enabled.
  assumes run is a level from the oscillator fault detector.
*/
`timescale 1ns/100ps
module xfls_start_cnt (
  input  wire logic pclk,    // system clock
  input  wire logic presetn, // async reset, low
  input  wire logic en,      // counter enable
  input  wire logic run,     // fault seen during start
  output logic      fault    // start limit reached
);
  import xfls_pkg::*;

  xfls_cnt_t st;
  xfls_cnt_t next_st;

  always_comb begin
    next_st = st;
    if (!en) begin
      next_st.cnt   = '0;
      next_st.fault = 1'b0;
    end else if (run && (st.cnt != START_LIMIT)) begin
      next_st.cnt = st.cnt + 8'h01;
    end
    next_st.fault = en && (next_st.cnt == START_LIMIT);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign fault = st.fault;

  property p_cnt_off;
    @(posedge pclk) disable iff (!presetn) !en |=> (st.cnt == '0) && !fault;
  endproperty
  a_cnt_off: assert property (p_cnt_off) else $error("counter not cleared");

endmodule // xfls_start_cnt

/* hdl/xfls_top.sv */
/*
  crystal oscillator configuration and loop lock status, apb slave.
  assumes presetn is the power-on reset, puc_clear a synchronous
  power-up-clear pulse, and all status inputs synchronous to pclk.
*/
// The placing of the registers and register access over APB were chosen for this implementation.
`timescale 1ns/100ps
module xfls_top (
  input  wire logic                     pclk,           // system clock
  input  wire logic                     presetn,        // power-on reset, low
  input  wire logic                     puc_clear,      // power-up-clear pulse
  input  wire xfls_pkg::xfls_apb_req_t  apb_req,        // apb request
  output logic [xfls_pkg::DW-1:0]       prdata,         // apb read data
  output logic                          pready,         // apb ready
  output logic                          pslverr,        // apb error
  input  wire xfls_pkg::xfls_loop_sts_t loop_sts,       // loop comparator
  input  wire logic                     xtal_fault_in,  // crystal fault cond
  input  wire logic                     ref_osc_stable, // reference stable
  input  wire logic                     aclk_use,       // aux clock uses xtal
  input  wire logic                     mclk_use,       // main clock uses xtal
  input  wire logic                     sub_main_clock_use,      // sub-main uses xtal
  input  wire logic                     loop_ref_use,   // loop ref needs xtal
  input  wire logic                     port_sel_xtal,  // port selects xtal
  input  wire logic                     puc_serviced,   // reset serviced
  output logic                          xtal_osc_en,    // oscillator run
  output logic                          xtal_from_pin,  // clock from pin
  output logic [1:0]                    hf_xtal_range,  // range select
  output logic                          xtal_gain_ctrl_off, // agc off
  output logic                          osc_fault_irq,  // fault irq request
  output logic                          power_up_clear_req, // reset request
  output logic                          xtal_start_fault    // start limit hit
);
  import xfls_pkg::*;

  xfls_state_t st;
  xfls_state_t next_st;

  logic       setup;
  logic       done;
  logic       wr_cfg;
  logic       wr_sts;
  logic [1:0] hist;
  logic       xt_flt;
  logic       lp_flt;
  logic       cnt_fault;
  logic       any_use;
  logic [DW-1:0] cfg_word;
  logic [DW-1:0] sts_word;

  assign setup  = apb_req.psel && !apb_req.penable;
  assign done   = apb_req.psel && apb_req.penable && st.pready;
  assign wr_cfg = done && apb_req.pwrite && (apb_req.paddr == CFG_OFS);
  assign wr_sts = done && apb_req.pwrite && (apb_req.paddr == STS_OFS);
  assign any_use = aclk_use || mclk_use || sub_main_clock_use || loop_ref_use;

  xfls_sticky #(.RST_VAL(HIST_RST[0])) u_hist_slow (
    .pclk    (pclk),
    .presetn (presetn),
    .set     (st.unlock_now == UNLOCK_SLOW),
    .clr     (wr_sts && !apb_req.pwdata[STS_HIST_LSB]),
    .q       (hist[0])
  );

  xfls_sticky #(.RST_VAL(HIST_RST[1])) u_hist_fast (
    .pclk    (pclk),
    .presetn (presetn),
    .set     (st.unlock_now == UNLOCK_FAST),
    .clr     (wr_sts && !apb_req.pwdata[STS_HIST_LSB+1]),
    .q       (hist[1])
  );

  xfls_sticky #(.RST_VAL(1'h0)) u_xtal_fault (
    .pclk    (pclk),
    .presetn (presetn),
    .set     (xtal_fault_in || cnt_fault),
    .clr     ((wr_sts && !apb_req.pwdata[STS_XTFLT_BIT]) || puc_clear),
    .q       (xt_flt)
  );

  xfls_sticky #(.RST_VAL(1'h0)) u_loop_fault (
    .pclk    (pclk),
    .presetn (presetn),
    .set     ((loop_sts.tap == TAP_MIN) || (loop_sts.tap == TAP_MAX)),
    .clr     ((wr_sts && !apb_req.pwdata[STS_LPFLT_BIT]) || puc_clear),
    .q       (lp_flt)
  );

  xfls_start_cnt u_start_cnt (
    .pclk    (pclk),
    .presetn (presetn),
    .en      (st.cnt_en),
    .run     (xtal_fault_in && st.xtal_en),
    .fault   (cnt_fault)
  );

  always_comb begin
    cfg_word = '0;
    cfg_word[CFG_BYPASS_BIT] = st.bypass;
    cfg_word[CFG_RANGE_LSB +: 2] = st.range;
    cfg_word[CFG_AGC_BIT] = st.agc_off;
    cfg_word[CFG_AUTO_BIT] = st.auto_off;
    sts_word = '0;
    sts_word[STS_WARN_BIT] = st.warn_en;
    sts_word[STS_ULPUC_BIT] = st.ulpuc_en;
    sts_word[STS_HIST_LSB +: 2] = hist;
    sts_word[STS_UNLOCK_LSB +: 2] = st.unlock_now;
    sts_word[STS_CNTEN_BIT] = st.cnt_en;
    sts_word[STS_ULIFG_BIT] = st.ulifg;
    sts_word[STS_REFRDY_BIT] = st.ref_ready;
    sts_word[STS_XTFLT_BIT] = xt_flt;
    sts_word[STS_LPFLT_BIT] = lp_flt;
  end

  always_comb begin
    next_st = st;
    // apb: one wait-free access phase after setup
    next_st.pready = setup;
    next_st.pslverr = 1'b0;
    if (setup) begin
      if (apb_req.paddr == CFG_OFS) begin
        next_st.prdata = cfg_word;
      end else if (apb_req.paddr == STS_OFS) begin
        next_st.prdata = sts_word;
      end else begin
        next_st.prdata = '0;
        next_st.pslverr = 1'b1;
      end
    end
    if (wr_cfg) begin
      next_st.bypass   = apb_req.pwdata[CFG_BYPASS_BIT];
      next_st.range    = apb_req.pwdata[CFG_RANGE_LSB +: 2];
      next_st.agc_off  = apb_req.pwdata[CFG_AGC_BIT];
      next_st.auto_off = apb_req.pwdata[CFG_AUTO_BIT];
    end
    if (wr_sts) begin
      next_st.warn_en  = apb_req.pwdata[STS_WARN_BIT];
      next_st.ulpuc_en = apb_req.pwdata[STS_ULPUC_BIT];
      next_st.cnt_en   = apb_req.pwdata[STS_CNTEN_BIT];
    end
    if (puc_serviced) begin
      next_st.ulpuc_en = 1'b0;
    end
    // current unlock condition
    if (lp_flt || loop_sts.out_of_range) begin
      next_st.unlock_now = UNLOCK_ERROR;
    end else if (loop_sts.too_fast && loop_sts.too_slow) begin
      next_st.unlock_now = UNLOCK_ERROR;
    end else if (loop_sts.too_fast) begin
      next_st.unlock_now = UNLOCK_FAST;
    end else if (loop_sts.too_slow) begin
      next_st.unlock_now = UNLOCK_SLOW;
    end else begin
      next_st.unlock_now = UNLOCK_LOCKED;
    end
    next_st.ulifg = (st.unlock_now == UNLOCK_FAST);
    next_st.ref_ready = ref_osc_stable;
    // oscillator control
    if (st.auto_off) begin
      next_st.xtal_en = any_use && !st.bypass;
    end else begin
      next_st.xtal_en = port_sel_xtal && !st.bypass;
    end
    next_st.from_pin = st.bypass;
    next_st.hf_range = st.range;
    next_st.agc_out  = st.agc_off;
    next_st.irq = xt_flt || lp_flt || (st.warn_en && (hist != 2'h0));
    next_st.puc_req = st.ulpuc_en && st.ulifg;
    if (puc_clear) begin
      next_st.bypass   = 1'b0;
      next_st.range    = RANGE_RST;
      next_st.agc_off  = 1'b0;
      next_st.auto_off = AUTO_OFF_RST;
      next_st.warn_en  = 1'b0;
      next_st.ulpuc_en = 1'b0;
      next_st.cnt_en   = CNT_EN_RST;
      next_st.puc_req  = 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st            <= '0;
      st.auto_off   <= AUTO_OFF_RST;
      st.range      <= RANGE_RST;
      st.cnt_en     <= CNT_EN_RST;
      st.unlock_now <= UNLOCK_RST;
    end else begin
      st <= next_st;
    end
  end

  assign prdata             = st.prdata;
  assign pready             = st.pready;
  assign pslverr            = st.pslverr;
  assign xtal_osc_en        = st.xtal_en;
  assign xtal_from_pin      = st.from_pin;
  assign hf_xtal_range      = st.hf_range;
  assign xtal_gain_ctrl_off = st.agc_out;
  assign osc_fault_irq      = st.irq;
  assign power_up_clear_req = st.puc_req;
  assign xtal_start_fault   = cnt_fault;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_cfg_write_bypass;
    wr_cfg && apb_req.pwdata[CFG_BYPASS_BIT] && !puc_clear;
  endsequence
  property p_bypass;
    s_cfg_write_bypass |=> ##1 xtal_from_pin;
  endproperty
  a_bypass: assert property (p_bypass) else $error("bypass not applied");

  property p_range;
    wr_cfg && !puc_clear |=> ##1 hf_xtal_range == $past(apb_req.pwdata[CFG_RANGE_LSB +: 2], 2);
  endproperty
  a_range: assert property (p_range) else $error("range not applied");

  property p_auto_off;
    st.auto_off && !any_use |=> !xtal_osc_en;
  endproperty
  a_auto_off: assert property (p_auto_off) else $error("oscillator not stopped");

  property p_manual_on;
    !st.auto_off && port_sel_xtal && !st.bypass |=> xtal_osc_en;
  endproperty
  a_manual_on: assert property (p_manual_on) else $error("oscillator not run");

  property p_warn;
    st.warn_en && (hist != 2'h0) |=> osc_fault_irq;
  endproperty
  a_warn: assert property (p_warn) else $error("warning irq missing");

  property p_puc;
    st.ulpuc_en && st.ulifg && !puc_clear |=> power_up_clear_req;
  endproperty
  a_puc: assert property (p_puc) else $error("reset not requested");

  property p_puc_no;
    !st.ulpuc_en |=> !power_up_clear_req;
  endproperty
  a_puc_no: assert property (p_puc_no) else $error("reset without enable");

  property p_serviced;
    puc_serviced |=> !st.ulpuc_en;
  endproperty
  a_serviced: assert property (p_serviced) else $error("enable not cleared");

  property p_hist_hold;
    hist[1] && !wr_sts |=> hist[1];
  endproperty
  a_hist_hold: assert property (p_hist_hold) else $error("history lost");

  property p_fault_unlock;
    lp_flt |=> st.unlock_now == UNLOCK_ERROR;
  endproperty
  a_fault_unlock: assert property (p_fault_unlock) else $error("unlock not 11b");

  sequence s_fast;
    st.unlock_now == UNLOCK_FAST;
  endsequence
  property p_ulifg;
    s_fast |=> st.ulifg ##0 (st.ulifg == ($past(st.unlock_now) == UNLOCK_FAST));
  endproperty
  a_ulifg: assert property (p_ulifg) else $error("unlock flag wrong");

  property p_reserved;
    setup && (apb_req.paddr == STS_OFS) |=> (prdata[15:14] == 2'h0) && !prdata[7]
      && !prdata[5] && !prdata[3];
  endproperty
  a_reserved: assert property (p_reserved) else $error("reserved bit set");

endmodule // xfls_top

/* testbench/xfls_xtal_model.sv */
/*
  far-side model: crystal source, reference oscillator and loop comparator.
  assumes the bench sets the cmd inputs right after a rising edge.
*/
`timescale 1ns/100ps
module xfls_xtal_model #(
  parameter int         REF_DLY  = 4,
  parameter logic [8:0] TAP_IDLE = 9'h100 // mid-range tap, clear of both rails
) (
  input  wire logic                pclk,           // system clock
  input  wire logic                presetn,        // reset, low
  input  wire logic                fault_cmd,      // bench: crystal fault
  input  wire logic [1:0]          loop_cmd,       // bench: lock/slow/fast/oor
  input  wire logic [8:0]          tap_cmd,        // bench: loop tap
  output xfls_pkg::xfls_loop_sts_t loop_sts,       // comparator result
  output logic                     xtal_fault_in,  // fault condition
  output logic                     ref_osc_stable  // reference settled
);
  import xfls_pkg::*;
  int cnt;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt            <= 0;
      ref_osc_stable <= 1'b0;
      loop_sts       <= {3'h0, TAP_IDLE}; // a rail tap here would fake a loop fault
      xtal_fault_in  <= 1'b0;
    end else begin
      if (cnt < REF_DLY) begin
        cnt <= cnt + 1;
      end
      ref_osc_stable <= (cnt == REF_DLY);
      loop_sts       <= {loop_cmd == 2'h1, loop_cmd == 2'h2, loop_cmd == 2'h3, tap_cmd};
      xtal_fault_in  <= fault_cmd;
    end
  end
endmodule // xfls_xtal_model

/* testbench/tb.sv */
/*
  self-checking bench for the crystal config and loop lock status block.
  assumes zero-wait apb answers and the far-side model beside the dut.
*/
`timescale 1ns/100ps
`define CHK(g, x) begin comparisons++; if ((g) !== (x)) begin errors++; \
  $display("wrong value at %0t: got %h expected %h", $time, g, x); end end
module tb;
  import xfls_pkg::*;
  logic pclk = 0, presetn = 0, puc_clear = 0, port_sel = 0, serviced = 0, fault_cmd = 0;
  logic [3:0] uses = 0;
  logic [1:0] loop_cmd = 0;
  logic [8:0] tap_cmd = 9'h100;
  xfls_apb_req_t req = '0;
  xfls_loop_sts_t loop_sts;
  logic [31:0] prdata;
  logic pready, pslverr, fault_in, ref_ok, osc_en, from_pin, gain_off, irq, puc_req, st_flt;
  logic [1:0] range;
  int errors = 0, comparisons = 0;

  always #2.5 pclk = ~pclk;

  xfls_xtal_model xm_u (.pclk(pclk), .presetn(presetn), .fault_cmd(fault_cmd),
    .loop_cmd(loop_cmd), .tap_cmd(tap_cmd), .loop_sts(loop_sts),
    .xtal_fault_in(fault_in), .ref_osc_stable(ref_ok));

  xfls_top dut_u (.pclk(pclk), .presetn(presetn), .puc_clear(puc_clear), .apb_req(req),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .loop_sts(loop_sts),
    .xtal_fault_in(fault_in), .ref_osc_stable(ref_ok), .aclk_use(uses[0]),
    .mclk_use(uses[1]), .sub_main_clock_use(uses[2]), .loop_ref_use(uses[3]),
    .port_sel_xtal(port_sel), .puc_serviced(serviced), .xtal_osc_en(osc_en),
    .xtal_from_pin(from_pin), .hf_xtal_range(range), .xtal_gain_ctrl_off(gain_off),
    .osc_fault_irq(irq), .power_up_clear_req(puc_req), .xtal_start_fault(st_flt));

  task automatic close_out();
    $display("errors %0d comparisons %0d", errors, comparisons);
    if (errors == 0 && comparisons > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge pclk);
  endtask

  // one apb transfer, then one idle cycle
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] r, output logic e);
    int n;
    n = 0;
    req.psel <= 1'b1; req.penable <= 1'b0; req.pwrite <= w; req.paddr <= a; req.pwdata <= d;
    @(posedge pclk);
    req.penable <= 1'b1;
    do begin @(posedge pclk); n++; end while (pready !== 1'b1 && n < 20);
    r = prdata;
    e = pslverr;
    if (pready !== 1'b1) begin errors++; close_out(); end
    req.psel <= 1'b0; req.penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] r; logic e;
    apb(1'b1, a, d, r, e);
    cyc(3);
  endtask

  task automatic rdchk(input logic [11:0] a, input logic [31:0] m, input logic [31:0] x);
    logic [31:0] r; logic e;
    apb(1'b0, a, 32'h0, r, e);
    `CHK(r & m, x)
  endtask

  task automatic t_reset();
    cyc(8);
    rdchk(CFG_OFS, 32'hffffffff, 32'h00000001);
    rdchk(STS_OFS, 32'hfffffcff, 32'h00000444);
    `CHK(osc_en, 1'b0)
  endtask

  task automatic t_config();
    port_sel <= 1'b1;
    for (int i = 0; i < 4; i++) begin
      wr(CFG_OFS, {27'h0, 1'b1, 2'(i), 1'b1, 1'b0});
      `CHK(range, 2'(i))
      `CHK({from_pin, gain_off, osc_en}, 3'b110)
      rdchk(CFG_OFS, 32'h1f, {27'h0, 1'b1, 2'(i), 2'b10});
    end
    wr(CFG_OFS, 32'h0);
    `CHK({from_pin, gain_off}, 2'b00)
  endtask

  task automatic t_auto();
    wr(CFG_OFS, 32'h1);
    for (int i = 0; i < 4; i++) begin
      uses <= 4'(1 << i);
      cyc(4);
      `CHK(osc_en, 1'b1)
    end
    uses <= 4'h0;
    cyc(4);
    `CHK(osc_en, 1'b0)
    wr(CFG_OFS, 32'h0);
    `CHK(osc_en, 1'b1)
    port_sel <= 1'b0;
    cyc(4);
    `CHK(osc_en, 1'b0)
  endtask

  task automatic t_unlock();
    for (int c = 0; c < 5; c++) begin
      loop_cmd <= 2'(c);
      cyc(6);
      rdchk(STS_OFS, 32'h310, {22'h0, 2'(c), 3'h0, c == 2, 4'h0});
    end
  endtask

  task automatic t_history();
    wr(STS_OFS, 32'h40);
    rdchk(STS_OFS, 32'hc00, 32'h0);
    for (int c = 2; c > 0; c--) begin
      loop_cmd <= 2'(c);
      cyc(6);
      loop_cmd <= 2'h0;
      cyc(6);
      rdchk(STS_OFS, 32'hc00, c == 2 ? 32'h800 : 32'hc00);
    end
    `CHK(irq, 1'b0)
    wr(STS_OFS, 32'h2c40);
    `CHK(irq, 1'b1)
    rdchk(STS_OFS, 32'hc00, 32'hc00);
    wr(STS_OFS, 32'h2040);
    `CHK(irq, 1'b0)
    wr(STS_OFS, 32'h40);
  endtask

  task automatic t_puc();
    wr(STS_OFS, 32'h1040);
    `CHK(puc_req, 1'b0)
    loop_cmd <= 2'h2;
    cyc(8);
    `CHK(puc_req, 1'b1)
    loop_cmd <= 2'h0;
    serviced <= 1'b1;
    @(posedge pclk);
    serviced <= 1'b0;
    cyc(3);
    rdchk(STS_OFS, 32'h1000, 32'h0);
    loop_cmd <= 2'h2;
    cyc(8);
    `CHK(puc_req, 1'b0)
    loop_cmd <= 2'h0;
    cyc(4);
    wr(STS_OFS, 32'h40);
  endtask

  task automatic t_faults();
    for (int i = 0; i < 2; i++) begin
      tap_cmd <= i ? TAP_MAX : TAP_MIN;
      cyc(6);
      wr(STS_OFS, 32'h40);
      rdchk(STS_OFS, 32'h301, 32'h301);
      `CHK(irq, 1'b1)
    end
    tap_cmd <= 9'h100;
    cyc(4);
    wr(STS_OFS, 32'h40);
    rdchk(STS_OFS, 32'h301, 32'h0);
    fault_cmd <= 1'b1;
    cyc(4);
    wr(STS_OFS, 32'h40);
    rdchk(STS_OFS, 32'h2, 32'h2);
    `CHK(irq, 1'b1)
    fault_cmd <= 1'b0;
    cyc(4);
    wr(STS_OFS, 32'h40);
    rdchk(STS_OFS, 32'h2, 32'h0);
    `CHK(irq, 1'b0)
  endtask

  task automatic t_counter();
    port_sel <= 1'b1;
    wr(STS_OFS, 32'h0);
    rdchk(STS_OFS, 32'h40, 32'h0);
    fault_cmd <= 1'b1;
    cyc(220);
    `CHK(st_flt, 1'b0)
    wr(STS_OFS, 32'h40);
    cyc(220);
    `CHK(st_flt, 1'b1)
    fault_cmd <= 1'b0;
    port_sel <= 1'b0;
    wr(STS_OFS, 32'h0);
    `CHK(st_flt, 1'b0)
    wr(STS_OFS, 32'h40);
  endtask

  task automatic t_reserved();
    logic [31:0] r; logic e;
    wr(STS_OFS, 32'hffffffff);
    rdchk(STS_OFS, 32'hffffc0b8, 32'h0);
    wr(STS_OFS, 32'h40);
    apb(1'b0, 12'h010, 32'h0, r, e);
    `CHK({e, r}, 33'h100000000)
  endtask

  // power-up-clear restores config and enables, history survives
  task automatic t_puc_clear();
    wr(CFG_OFS, 32'h1e);
    loop_cmd <= 2'h1;
    cyc(6);
    loop_cmd <= 2'h0;
    wr(STS_OFS, 32'h3400);
    `CHK(irq, 1'b1)
    puc_clear <= 1'b1;
    @(posedge pclk);
    puc_clear <= 1'b0;
    cyc(3);
    `CHK({from_pin, range, gain_off, irq}, 5'h00)
    rdchk(CFG_OFS, 32'h1f, 32'h1);
    rdchk(STS_OFS, 32'h3c40, 32'h440);
  endtask

  initial begin
    cyc(16);
    presetn <= 1'b1;
    @(posedge pclk);
    t_reset();
    t_config();
    t_auto();
    t_unlock();
    t_history();
    t_puc();
    t_faults();
    t_counter();
    t_reserved();
    t_puc_clear();
    close_out();
  end
endmodule // tb
